// ### mgd_map.vh
// Register map, reset values and timing counts of the gap and frame-length unit
// Behaviour
// - Carrier seen inside the carrier window restarts the gap, deferring transmission.
// - Carrier after the window is ignored if a frame waits at gap end; gap finishes and the frame goes out. With none waiting, carrier restarts the gap.
// - Carrier window is bits 6:0, bit 7 reads zero, resets to 0Ch.
// - Spaced gap count resets to 12h, the standard minimum gap.
// - Spaced gap count is bits 6:0 writable; bit 7 read-only zero.
// - Maximum receive frame length resets to 0600h, 1536 bytes.
// - With skip header CRC set, first 4 frame bytes bypass the CRC.
// - Spaced gap lasts six intrinsic transmit clocks plus the programmed count.
// - Carrier sense passes a two-flop synchroniser before the transmit machine sees it.
`ifndef MGD_MAP_VH
`define MGD_MAP_VH

// Register indices; byte address is four times the index
`define MGD_IDX_WINDOW      10'h02E
`define MGD_IDX_GAP         10'h02F
`define MGD_IDX_MAX_RX_FRAME_LEN_LOW    10'h030
`define MGD_IDX_MAX_RX_FRAME_LEN_HIGH   10'h031
`define MGD_IDX_CONFIG      10'h040
`define MGD_IDX_STATUS      10'h041
`define MGD_IDX_RX_LEN      10'h042

// Reset values
`define MGD_RST_WINDOW      7'h0C
`define MGD_RST_GAP         7'h12
`define MGD_RST_MAX_RX_FRAME_LEN        16'h0600

// Field positions
`define MGD_CFG_SKIP_CRC    0
`define MGD_ST_TX_SENDING   0
`define MGD_ST_GAP_DONE     1
`define MGD_ST_OVERSIZE     2
`define MGD_ST_CRC_ERROR    3
`define MGD_ST_RX_ACTIVE    4
`define MGD_ST_CARRIER      5

// Counts: gap in transmit clock periods, header skip in bytes
`define MGD_GAP_INTRINSIC   8'h06
`define MGD_SKIP_BYTES      16'h0004

// Receive CRC
`define MGD_CRC_POLY        32'hEDB88320
`define MGD_CRC_INIT        32'hFFFFFFFF
`define MGD_CRC_RESIDUE     32'hDEBB20E3

`endif

// ### mgd_sync.v
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module mgd_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,     // Sampling clock
  input  wire             rst_n,   // Async reset, active low
  input  wire [WIDTH-1:0] din,     // Asynchronous inputs
  output reg  [WIDTH-1:0] dout     // Synchronised outputs
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // mgd_sync
`default_nettype wire

// ### mgd_crc.v
// Byte-wide Ethernet CRC-32 accumulator with residue check
`timescale 1ns/1ps
`default_nettype none
`include "mgd_map.vh"
module mgd_crc (
  input  wire       clk,     // Clock
  input  wire       rst_n,   // Async reset, active low
  input  wire       init,    // Restart accumulation
  input  wire       en,      // Fold in one byte
  input  wire [7:0] data,    // Byte, lsb first on the wire
  output wire       match    // Residue of a good frame
);

  reg [31:0] crc;

  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg [31:0]   r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0] ^ d[i])
          r = (r >> 1) ^ `MGD_CRC_POLY;
        else
          r = r >> 1;
      end
      crc_byte = r;
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      crc <= `MGD_CRC_INIT;
    else if (init)
      crc <= `MGD_CRC_INIT;
    else if (en)
      crc <= crc_byte(crc, data);
  end

  assign match = (crc == `MGD_CRC_RESIDUE);

endmodule // mgd_crc
`default_nettype wire

// ### mgd_top.v
// Transmit gap deferral and receive frame length check with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "mgd_map.vh"
module mgd_top (
  input  wire        pclk,          // APB clock
  input  wire        presetn,       // Async reset, active low
  input  wire        psel,          // APB select
  input  wire        penable,       // APB access phase
  input  wire        pwrite,        // APB write
  input  wire [11:0] paddr,         // APB byte address
  input  wire [31:0] pwdata,        // APB write data
  input  wire [3:0]  pstrb,         // APB byte strobes
  output reg  [31:0] prdata,        // APB read data
  output wire        pready,        // APB ready
  output wire        pslverr,       // APB error, unmapped address
  input  wire        mii_tx_clk,    // PHY transmit clock
  input  wire        mii_crs,       // PHY carrier sense
  output reg  [3:0]  mii_txd,       // Transmit nibble
  output reg         mii_tx_en,     // Transmit enable
  input  wire        mii_rx_dv,     // Receive data valid
  input  wire [3:0]  mii_rxd,       // Receive nibble
  input  wire        tx_valid,      // Frame byte offered
  input  wire [7:0]  tx_data,       // Frame byte
  input  wire        tx_last,       // Last byte of frame
  output wire        tx_ready,      // Frame byte taken
  output reg  [7:0]  rx_data,       // Received byte
  output reg         rx_data_valid, // Received byte pulse
  output reg         rx_frame_done, // End of frame pulse
  output reg  [15:0] rx_frame_len,  // Bytes of last frame
  output reg         rx_oversize,   // Last frame too long
  output reg         rx_crc_error   // Last frame bad CRC
);

  localparam ST_IDLE = 3'b001;
  localparam ST_GAP  = 3'b010;
  localparam ST_SEND = 3'b100;

  // Registers
  reg [6:0]  carrier_window_count;
  reg [6:0]  spaced_gap_count;
  reg [15:0] max_rx_frame_len;
  reg        skip_header_crc;

  // Synchronised pins
  wire [6:0] pins_s;
  wire       tx_clk_s;
  wire       crs_s;
  wire       rx_dv_s;
  wire [3:0] rxd_s;
  reg        tx_clk_d;
  wire       tick;

  // Transmit state
  reg [2:0]  state;
  reg [7:0]  gap_cnt;
  reg        nib_hi;
  wire [7:0] win_end;
  wire [7:0] gap_end;
  wire       gap_done;

  // Receive state
  reg        rx_active;
  reg        rx_hi;
  reg [3:0]  rx_lo;
  reg [15:0] rx_cnt;
  wire       rx_byte;
  wire       rx_end;
  wire       crc_en;
  wire       crc_match;

  // APB decode
  wire       setup;
  wire       wr;
  wire       mapped;

  function addr_hit;
    input [11:0] a;
    begin
      case (a[11:2])
        `MGD_IDX_WINDOW, `MGD_IDX_GAP, `MGD_IDX_MAX_RX_FRAME_LEN_LOW, `MGD_IDX_MAX_RX_FRAME_LEN_HIGH,
        `MGD_IDX_CONFIG, `MGD_IDX_STATUS, `MGD_IDX_RX_LEN:
          addr_hit = (a[1:0] == 2'b00);
        default:
          addr_hit = 1'b0;
      endcase
    end
  endfunction

  function wr_hit;
    input [11:0] a;
    input [9:0]  idx;
    begin
      wr_hit = (a[11:2] == idx) && (a[1:0] == 2'b00);
    end
  endfunction

  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite & pstrb[0];
  assign mapped  = addr_hit(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_window_count <= `MGD_RST_WINDOW;
      spaced_gap_count     <= `MGD_RST_GAP;
      max_rx_frame_len     <= `MGD_RST_MAX_RX_FRAME_LEN;
      skip_header_crc      <= 1'b0;
    end else if (wr) begin
      if (wr_hit(paddr, `MGD_IDX_WINDOW))
        carrier_window_count <= pwdata[6:0];
      if (wr_hit(paddr, `MGD_IDX_GAP))
        spaced_gap_count <= pwdata[6:0];
      if (wr_hit(paddr, `MGD_IDX_MAX_RX_FRAME_LEN_LOW))
        max_rx_frame_len[7:0] <= pwdata[7:0];
      if (wr_hit(paddr, `MGD_IDX_MAX_RX_FRAME_LEN_HIGH))
        max_rx_frame_len[15:8] <= pwdata[7:0];
      if (wr_hit(paddr, `MGD_IDX_CONFIG))
        skip_header_crc <= pwdata[`MGD_CFG_SKIP_CRC];
    end
  end

  // Read data, captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= 32'h00000000;
      case (paddr[11:2])
        `MGD_IDX_WINDOW:    prdata[6:0] <= carrier_window_count;
        `MGD_IDX_GAP:       prdata[6:0] <= spaced_gap_count;
        `MGD_IDX_MAX_RX_FRAME_LEN_LOW:  prdata[7:0] <= max_rx_frame_len[7:0];
        `MGD_IDX_MAX_RX_FRAME_LEN_HIGH: prdata[7:0] <= max_rx_frame_len[15:8];
        `MGD_IDX_CONFIG:    prdata[`MGD_CFG_SKIP_CRC] <= skip_header_crc;
        `MGD_IDX_STATUS: begin
          prdata[`MGD_ST_TX_SENDING] <= (state == ST_SEND);
          prdata[`MGD_ST_GAP_DONE]   <= gap_done;
          prdata[`MGD_ST_OVERSIZE]   <= rx_oversize;
          prdata[`MGD_ST_CRC_ERROR]  <= rx_crc_error;
          prdata[`MGD_ST_RX_ACTIVE]  <= rx_active;
          prdata[`MGD_ST_CARRIER]    <= crs_s;
        end
        `MGD_IDX_RX_LEN:    prdata[15:0] <= rx_frame_len;
        default:            prdata <= 32'h00000000;
      endcase
      if (paddr[1:0] != 2'b00)
        prdata <= 32'h00000000;
    end
  end

  // Pin synchronisers
  mgd_sync #(
    .WIDTH (7)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({mii_rxd, mii_rx_dv, mii_crs, mii_tx_clk}),
    .dout  (pins_s)
  );

  assign tx_clk_s = pins_s[0];
  assign crs_s    = pins_s[1];
  assign rx_dv_s  = pins_s[2];
  assign rxd_s    = pins_s[6:3];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_clk_d <= 1'b0;
    else
      tx_clk_d <= tx_clk_s;
  end

  // One pulse per transmit clock period
  assign tick = tx_clk_s & ~tx_clk_d;

  // Gap bounds in transmit clocks
  assign win_end  = `MGD_GAP_INTRINSIC + {1'b0, carrier_window_count};
  assign gap_end  = `MGD_GAP_INTRINSIC + {1'b0, spaced_gap_count};
  assign gap_done = (state == ST_GAP) && (gap_cnt >= gap_end);

  assign tx_ready = (state == ST_SEND) & tick & nib_hi & tx_valid;

  // Transmit machine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      gap_cnt   <= 8'h00;
      nib_hi    <= 1'b0;
      mii_txd   <= 4'h0;
      mii_tx_en <= 1'b0;
    end else if (tick) begin
      case (state)
        ST_IDLE: begin
          gap_cnt <= 8'h00;
          state   <= ST_GAP;
        end
        ST_GAP: begin
          mii_tx_en <= 1'b0;
          mii_txd   <= 4'h0;
          nib_hi    <= 1'b0;
          if (crs_s && (gap_cnt < win_end))
            gap_cnt <= 8'h00;
          else if (gap_cnt < gap_end)
            gap_cnt <= gap_cnt + 8'h01;
          else if (tx_valid)
            state <= ST_SEND;
          else if (crs_s)
            gap_cnt <= 8'h00;
        end
        ST_SEND: begin
          if (!nib_hi) begin
            if (tx_valid) begin
              mii_txd   <= tx_data[3:0];
              mii_tx_en <= 1'b1;
              nib_hi    <= 1'b1;
            end else begin
              mii_tx_en <= 1'b0;
              gap_cnt   <= 8'h00;
              state     <= ST_GAP;
            end
          end else begin
            nib_hi <= 1'b0;
            if (tx_valid) begin
              mii_txd <= tx_data[7:4];
              if (tx_last) begin
                gap_cnt <= 8'h00;
                state   <= ST_GAP;
              end
            end else begin
              mii_tx_en <= 1'b0;
              gap_cnt   <= 8'h00;
              state     <= ST_GAP;
            end
          end
        end
        default: begin
          state     <= ST_IDLE;
          mii_tx_en <= 1'b0;
        end
      endcase
    end
  end

  // Receive byte assembly and frame end
  assign rx_byte = tick & rx_dv_s & rx_hi;
  assign rx_end  = tick & ~rx_dv_s & rx_active;
  assign crc_en  = rx_byte & ~(skip_header_crc && (rx_cnt < `MGD_SKIP_BYTES));

  mgd_crc u_crc (
    .clk   (pclk),
    .rst_n (presetn),
    .init  (rx_end),
    .en    (crc_en),
    .data  ({rxd_s, rx_lo}),
    .match (crc_match)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_active     <= 1'b0;
      rx_hi         <= 1'b0;
      rx_lo         <= 4'h0;
      rx_cnt        <= 16'h0000;
      rx_data       <= 8'h00;
      rx_data_valid <= 1'b0;
      rx_frame_done <= 1'b0;
      rx_frame_len  <= 16'h0000;
      rx_oversize   <= 1'b0;
      rx_crc_error  <= 1'b0;
    end else begin
      rx_data_valid <= 1'b0;
      rx_frame_done <= 1'b0;
      if (tick && rx_dv_s) begin
        rx_active <= 1'b1;
        if (!rx_hi) begin
          rx_lo <= rxd_s;
          rx_hi <= 1'b1;
        end else begin
          rx_hi         <= 1'b0;
          rx_data       <= {rxd_s, rx_lo};
          rx_data_valid <= 1'b1;
          if (rx_cnt != 16'hFFFF)
            rx_cnt <= rx_cnt + 16'h0001;
        end
      end else if (rx_end) begin
        rx_active     <= 1'b0;
        rx_hi         <= 1'b0;
        rx_cnt        <= 16'h0000;
        rx_frame_done <= 1'b1;
        rx_frame_len  <= rx_cnt;
        rx_oversize   <= (rx_cnt > max_rx_frame_len);
        rx_crc_error  <= ~crc_match;
      end
    end
  end

endmodule // mgd_top
`default_nettype wire

// ### mgd_monitor.sv
// Port checker for the gap deferral and frame length unit
`timescale 1ns/1ps
`default_nettype none
module mgd_monitor #(parameter int TICK = 16) (
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Reset, active low
  input wire logic        psel,          // Select
  input wire logic        penable,       // Access phase
  input wire logic        pwrite,        // Write
  input wire logic [11:0] paddr,         // Address
  input wire logic [31:0] pwdata,        // Write data
  input wire logic [3:0]  pstrb,         // Strobes
  input wire logic [31:0] prdata,        // Read data
  input wire logic        pslverr,       // Error
  input wire logic        mii_crs,       // Carrier
  input wire logic        mii_tx_en,     // Transmit enable
  input wire logic        tx_valid,      // Byte offered
  input wire logic        rx_frame_done, // Frame end
  input wire logic [15:0] rx_frame_len,  // Frame length
  input wire logic        rx_oversize    // Oversize flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rd  = acc && !pwrite;
  logic [6:0]  win, gap;
  logic [7:0]  mfl, mfh;
  logic [15:0] lowc, valc, sinc;
  logic        dly, dfr;
  // Shadow registers and idle, offer and carrier-free counters
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win  <= 7'h0C;
      gap  <= 7'h12;
      mfl  <= 8'h00;
      mfh  <= 8'h06;
      lowc <= 16'h0000;
      valc <= 16'h0000;
      sinc <= 16'h0000;
      dly  <= 1'b0;
      dfr  <= 1'b0;
    end else begin
      if (acc && pwrite && pstrb[0]) begin
        case (paddr)
          12'hB8: win <= pwdata[6:0];
          12'hBC: gap <= pwdata[6:0];
          12'hC0: mfl <= pwdata[7:0];
          12'hC4: mfh <= pwdata[7:0];
          default: ;
        endcase
      end
      lowc <= mii_tx_en ? 16'h0000 : lowc + {15'h0000, lowc != 16'hFFFF};
      valc <= (mii_tx_en || !tx_valid) ? 16'h0000 : valc + {15'h0000, valc != 16'hFFFF};
      sinc <= mii_crs ? 16'h0000 : sinc + {15'h0000, sinc != 16'hFFFF};
      dly  <= !mii_tx_en && (dly || mii_crs && lowc < (5 + win) * TICK);
      dfr  <= !mii_tx_en && (dfr || mii_crs && (lowc < (8 + win) * TICK || !tx_valid));
    end
  end
  property p_win; rd && paddr == 12'hB8 |-> prdata == {25'h0, win}; endproperty
  a_win: assert property (p_win) else $error("window readback wrong");
  property p_gap; rd && paddr == 12'hBC |-> prdata == {25'h0, gap}; endproperty
  a_gap: assert property (p_gap) else $error("gap readback wrong");
  property p_mfl; rd && paddr == 12'hC0 |-> prdata == {24'h0, mfl}; endproperty
  a_mfl: assert property (p_mfl) else $error("length low readback wrong");
  property p_mfh; rd && paddr == 12'hC4 |-> prdata == {24'h0, mfh}; endproperty
  a_mfh: assert property (p_mfh) else $error("length high readback wrong");
  property p_gapl; $rose(mii_tx_en) |-> lowc + 8 >= (6 + gap) * TICK; endproperty
  a_gapl: assert property (p_gapl) else $error("transmit gap too short");
  property p_defer; $rose(mii_tx_en) && dly |-> sinc >= (5 + gap) * TICK; endproperty
  a_defer: assert property (p_defer) else $error("no deferral to carrier");
  property p_late; !mii_tx_en && !dfr |-> valc <= (9 + gap) * TICK; endproperty
  a_late: assert property (p_late) else $error("late carrier held frame");
  property p_over; rx_frame_done |=> rx_oversize == (rx_frame_len > {mfh, mfl}); endproperty
  a_over: assert property (p_over) else $error("oversize flag wrong");
  c_over: cover property (rx_frame_done ##1 rx_oversize);
  c_err: cover property (acc && pslverr);
  c_defer: cover property ($rose(mii_tx_en) && dly);
endmodule // mgd_monitor
bind mgd_top mgd_monitor mgd_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pslverr, .mii_crs, .mii_tx_en, .tx_valid,
  .rx_frame_done, .rx_frame_len, .rx_oversize);
`default_nettype wire

// ### mgd_phy_model.sv
// Behavioural PHY on the media-independent side of the unit
`timescale 1ns/1ps
`default_nettype none
module mgd_phy_model (
  output var logic       mii_tx_clk, // Transmit clock
  output var logic       mii_crs,    // Carrier sense
  output var logic       mii_rx_dv,  // Receive valid
  output var logic [3:0] mii_rxd,    // Receive nibble
  input wire logic [3:0] mii_txd,    // Transmit nibble
  input wire logic       mii_tx_en   // Transmit enable
);
  int         idle = 0, gap_seen = 0, crs_at = 1000000, crs_len = 0;
  logic       half = 1'b0, rxb = 1'b0;
  logic [3:0] lo;
  logic [7:0] txq[$];
  initial begin
    mii_tx_clk = 1'b0;
    forever #80 mii_tx_clk = ~mii_tx_clk;
  end
  initial begin
    mii_crs = 1'b0;
    mii_rx_dv = 1'b0;
    mii_rxd = 4'h0;
  end
  // Collects sent bytes, measures idle ticks, raises carrier on request
  always @(posedge mii_tx_clk) begin
    if (mii_tx_en) begin
      if (idle > 0) gap_seen <= idle;
      idle <= 0;
      if (half) txq.push_back({mii_txd, lo});
      lo <= mii_txd;
      half <= !half;
    end else begin
      idle <= idle + 1;
      half <= 1'b0;
    end
    mii_crs <= rxb || !mii_tx_en && idle >= crs_at && idle < crs_at + crs_len;
  end
  task automatic rx_frame(input logic [7:0] b[$]);
    rxb = 1'b1;
    foreach (b[i]) for (int h = 0; h < 2; h++) begin
      @(negedge mii_tx_clk);
      mii_rx_dv <= 1'b1;
      mii_rxd <= h ? b[i][7:4] : b[i][3:0];
    end
    @(negedge mii_tx_clk);
    mii_rx_dv <= 1'b0;
    mii_rxd <= ~mii_rxd;
    repeat (4) @(negedge mii_tx_clk);
    rxb = 1'b0;
  endtask
endmodule // mgd_phy_model
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the gap deferral and frame length unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, tx_valid, tx_last, err;
  logic        pready, pslverr, mii_tx_clk, mii_crs, mii_tx_en, mii_rx_dv, tx_ready;
  logic        rx_data_valid, rx_frame_done, rx_oversize, rx_crc_error;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, c;
  logic [3:0]  pstrb, mii_txd, mii_rxd;
  logic [7:0]  tx_data, rx_data, q[$], exp_q[$], rxq[$];
  logic [15:0] rx_frame_len;
  int          miscompares = 0, samples_checked = 0, seed = 51, g, n, k, dn = 0;
  mgd_top mgd_top_inst (.*);
  mgd_phy_model mgd_phy_model_inst (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (rx_frame_done === 1'b1) dn <= dn + 1;
  // Received bytes, one per data pulse
  always @(posedge pclk) if (rx_data_valid === 1'b1) rxq.push_back(rx_data);
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic bail(input int lim);
    if (k >= lim) begin
      chk("wait bound", 0, k);
      stop_test();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    bail(100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task automatic send_tx(input int len);
    for (int i = 0; i < len; i++) begin
      exp_q.push_back(8'($random(seed)));
      tx_valid <= 1'b1;
      tx_data <= exp_q[$];
      tx_last <= (i == len - 1);
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (tx_ready !== 1'b1 && k < 5000);
      bail(5000);
    end
  endtask
  function automatic logic [31:0] crc(input logic [7:0] b[$], input int s);
    logic [31:0] r = 32'hFFFFFFFF;
    for (int i = s; i < b.size(); i++)
      for (int j = 0; j < 8; j++)
        r = (r >> 1) ^ ((r[0] ^ b[i][j]) ? 32'hEDB88320 : 32'h0);
    return ~r;
  endfunction
  initial begin
    {psel, penable, pwrite, tx_valid, tx_last, presetn} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    tx_data = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'hB8, 32'h0C, "window reset");
    rdchk(12'hBC, 32'h12, "gap reset");
    rdchk(12'hC0, 32'h00, "length low reset");
    rdchk(12'hC4, 32'h06, "length high reset");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'hB8 + 12'(4 * i), 32'hFFFFFFFF);
      rdchk(12'hB8 + 12'(4 * i), i < 2 ? 32'h7F : 32'hFF, "field width");
    end
    apb(1'b0, 12'h0A0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    // No carrier, early carrier, carrier after the window
    for (int m = 0; m < 3; m++) begin
      g = 12 + ($random(seed) & 15);
      apb(1'b1, 12'hBC, 32'(g));
      apb(1'b1, 12'hB8, 32'(g / 2));
      send_tx(3);
      mgd_phy_model_inst.crs_at = m == 0 ? 1000000 : (m == 1 ? 2 : 4 + g);
      mgd_phy_model_inst.crs_len = m == 1 ? 8 : 1000;
      send_tx(4);
      tx_valid <= 1'b0;
      mgd_phy_model_inst.crs_at = 1000000;
      k = 0;
      while (mii_tx_en !== 1'b0 && k < 500) begin
        @(posedge pclk);
        k++;
      end
      bail(500);
      n = mgd_phy_model_inst.gap_seen;
      chk("gap ticks", {30'h0, m == 1, 1'b1}, {30'h0, n > 8 + g, n >= 6 + g});
    end
    foreach (exp_q[i]) chk("tx byte", exp_q[i], mgd_phy_model_inst.txq[i]);
    apb(1'b1, 12'hC0, 32'h10);
    apb(1'b1, 12'hC4, 32'h00);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h100, 32'(i >> 1));
      q.delete();
      rxq.delete();
      n = 12 + i % 2;
      repeat (n) q.push_back(8'($random(seed)));
      c = crc(q, (i % 2) * 4);
      for (int j = 0; j < 4; j++) q.push_back(c[8 * j +: 8]);
      mgd_phy_model_inst.rx_frame(q);
      chk("frame length", 32'(n + 4), {16'h0, rx_frame_len});
      chk("oversize", 32'(i % 2), {31'h0, rx_oversize});
      chk("crc error", 32'((i % 2) != (i >> 1)), {31'h0, rx_crc_error});
      chk("frame ends", 32'(i + 1), 32'(dn));
      chk("rx byte count", 32'(n + 4), 32'(rxq.size()));
      foreach (q[j]) chk("rx byte", {24'h0, q[j]}, {24'h0, rxq[j]});
      rdchk(12'h108, 32'(n + 4), "length register");
    end
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
